// >>> octal_switch_regs.vh
// constants of the octal switch serial control and diagnosis block
`ifndef OCTAL_SWITCH_REGS_VH
`define OCTAL_SWITCH_REGS_VH

`define FRAME_BITS        5'h10
`define FRAME_CNT_W       5
`define CTRL_DIAG_ONLY    8'h00
`define CODE_NO_FAULT     2'h3
`define CODE_OVERLOAD     2'h2
`define CODE_OPEN_LOAD    2'h1
`define CODE_SHORT_GND    2'h0
`define DIAG_RESET_VALUE  16'hffff
`define OUTPUT_RESET      8'h00
`define PAR_CHANNELS      4

`endif

// >>> sync2.v
// two-flop synchroniser for pins from outside the core clock domain
`timescale 1ns/1ps
`default_nettype none

module sync2 #(
    parameter W = 1
) (
    input  wire         core_clk,  // core clock
    input  wire         rst_n,     // synchronous reset, active low
    input  wire [W-1:0] async_in,  // raw pin level
    input  wire [W-1:0] rst_val,   // level held during reset
    output wire [W-1:0] sync_out   // synchronised level
);

    reg [W-1:0] meta_reg;
    reg [W-1:0] stable_reg;

    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            meta_reg   <= rst_val;
            stable_reg <= rst_val;
        end
        else
        begin
            meta_reg   <= async_in;
            stable_reg <= meta_reg;
        end
    end

    assign sync_out = stable_reg;

endmodule // sync2

`default_nettype wire

// >>> channel_diag.v
// held two-bit diagnosis code of one power channel
`timescale 1ns/1ps
`default_nettype none
`include "octal_switch_regs.vh"

module channel_diag (
    input  wire       core_clk,        // core clock
    input  wire       rst_n,           // synchronous reset, active low
    input  wire       overload,        // current limit active (sync)
    input  wire       open_load,       // open-load detector (sync)
    input  wire       short_gnd,       // short-to-ground detector (sync)
    input  wire       clear,           // one-cycle clear at frame end
    output reg  [1:0] code_reg         // held code, 2'h3 = no fault
);

    reg [1:0] live_code;
    reg [1:0] live_prev_reg;
    wire      new_error;

    // priority among simultaneous detectors: overload first
    always @*
    begin
        if (overload)
            live_code = `CODE_OVERLOAD;
        else if (short_gnd)
            live_code = `CODE_SHORT_GND;
        else if (open_load)
            live_code = `CODE_OPEN_LOAD;
        else
            live_code = `CODE_NO_FAULT;
    end

    // a fault that is present or appears right at the clear wins over it
    assign new_error = (live_code != `CODE_NO_FAULT) && (live_code != live_prev_reg);

    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            code_reg      <= `CODE_NO_FAULT;
            live_prev_reg <= `CODE_NO_FAULT;
        end
        else
        begin
            live_prev_reg <= live_code;
            if (new_error)
                code_reg <= live_code;
            else if (clear)
                code_reg <= live_code;
        end
    end

endmodule // channel_diag

`default_nettype wire

// >>> octal_switch_spi.v
// serial control and diagnosis logic of an eight-channel low-side switch
`timescale 1ns/1ps
`default_nettype none
`include "octal_switch_regs.vh"

// Operation
// - fault flag goes low as soon as any channel reports an error.
// - a fault is latched into the held diagnosis register.
// - a new error overwrites the code previously held for that channel.
// - serial data out is high impedance while chip select is high.
// - with chip select low all diagnosis bits shift out in turn.
// - rising chip select reloads every held code from the live detectors, so a fault still present stays held.
// - each channel reports a two-bit code, sixteen bits in total.
// - no fault reports high-high.
// - current limiting from overload, supply short or heat reports high-low.
// - open load reports low-high.
// - short to ground reports low-low.
// - control byte ff accepts the data byte as the new output state.
// - any control byte other than 00 is valid and the data is accepted.
// - control byte 00 is diagnosis only; data discarded, outputs unchanged.
// - outputs follow data bits; channels one to four ANDed with parallel inputs.
// - newly accepted outputs switch at the rising edge of chip select.
// - a frame is accepted only after exactly sixteen clock pulses.
// - input sampled msb first on falling clock; output changes on rising.
// - falling chip select loads the current diagnosis into the shift register.
// - reset low clears the input shift register, fills the output shift register with ones and forces all outputs off.
module octal_switch_spi (
    input  wire       core_clk,                // core clock, 250 MHz
    input  wire       rst_n,                   // synchronous reset, active low
    input  wire       cs_n,                    // chip select pin, active low
    input  wire       sclk,                    // serial clock pin
    input  wire       si,                      // serial data in pin
    output reg        so_o,                    // serial data out value
    output reg        so_oe,                   // serial data out enable
    output wire       fault_n_o,               // fault flag output, always 0
    output reg        fault_n_oe,              // fault flag enable, high pulls low
    input  wire       prg,                     // parallel inputs high active when 1
    input  wire       parallel_drive_input_1,  // parallel input channel 1
    input  wire       parallel_drive_input_2,  // parallel input channel 2
    input  wire       parallel_drive_input_3,  // parallel input channel 3
    input  wire       parallel_drive_input_4,  // parallel input channel 4
    input  wire [7:0] overload,                // current limit per channel
    input  wire [7:0] open_load,               // open-load detector per channel
    input  wire [7:0] short_gnd,               // short-to-ground detector per channel
    output reg  [7:0] power_output,            // channel on, bit 0 = channel 1
    output reg  [7:0] out_latch_reg            // serial switching state held
);

    wire [2:0]  pin_s;
    wire [3:0]  par_s;
    wire        prg_s;
    wire [23:0] det_s;
    wire        cs_n_s;
    wire        sclk_s;
    wire        si_s;
    reg         cs_n_d_reg;
    reg         sclk_d_reg;
    reg  [15:0] shift_in_reg;
    reg  [15:0] shift_out_reg;
    reg  [4:0]  pulse_cnt_reg;
    reg         cnt_over_reg;
    wire        cs_fall;
    wire        cs_rise;
    wire        sclk_rise;
    wire        sclk_fall;
    wire        frame_ok;
    wire [15:0] diag_word;
    wire [3:0]  par_active;
    reg  [7:0]  power_next;

    // pins cross into the core domain before any logic sees them
    sync2 #(
        .W (3)
    ) u_sync_spi (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .async_in ({cs_n, sclk, si}),
        .rst_val  (3'h4),
        .sync_out (pin_s)
    );

    // prg is a pin as well, so it shares the parallel synchroniser
    sync2 #(
        .W (5)
    ) u_sync_par (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .async_in ({prg, parallel_drive_input_4, parallel_drive_input_3,
                    parallel_drive_input_2, parallel_drive_input_1}),
        .rst_val  (5'h10),
        .sync_out ({prg_s, par_s})
    );

    sync2 #(
        .W (24)
    ) u_sync_det (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .async_in ({overload, open_load, short_gnd}),
        .rst_val  (24'h000000),
        .sync_out (det_s)
    );

    assign cs_n_s = pin_s[2];
    assign sclk_s = pin_s[1];
    assign si_s   = pin_s[0];

    assign cs_fall   = cs_n_d_reg && !cs_n_s;
    assign cs_rise   = !cs_n_d_reg && cs_n_s;
    // clock edges only count while selected; otherwise ignored
    assign sclk_rise = !cs_n_s && !cs_n_d_reg && !sclk_d_reg && sclk_s;
    assign sclk_fall = !cs_n_s && !cs_n_d_reg && sclk_d_reg && !sclk_s;

    // per-channel held diagnosis, codes packed channel 8 first
    genvar ch;
    generate
        for (ch = 0; ch < 8; ch = ch + 1)
        begin : g_diag
            channel_diag u_diag (
                .core_clk  (core_clk),
                .rst_n     (rst_n),
                .overload  (det_s[16 + ch]),
                .open_load (det_s[8 + ch]),
                .short_gnd (det_s[ch]),
                .clear     (cs_rise),
                .code_reg  (diag_word[2*ch+1:2*ch])
            );
        end
    endgenerate

    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            cs_n_d_reg <= 1'b1;
            sclk_d_reg <= 1'b0;
        end
        else
        begin
            cs_n_d_reg <= cs_n_s;
            sclk_d_reg <= sclk_s;
        end
    end

    // input shifter and pulse counter
    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            shift_in_reg  <= 16'h0000;
            pulse_cnt_reg <= 5'h00;
            cnt_over_reg  <= 1'b0;
        end
        else if (cs_fall)
        begin
            pulse_cnt_reg <= 5'h00;
            cnt_over_reg  <= 1'b0;
        end
        else if (sclk_fall)
        begin
            shift_in_reg <= {shift_in_reg[14:0], si_s};
            if (pulse_cnt_reg == `FRAME_BITS)
                cnt_over_reg <= 1'b1;
            else
                pulse_cnt_reg <= pulse_cnt_reg + 5'h01;
        end
    end

    assign frame_ok = (pulse_cnt_reg == `FRAME_BITS) && !cnt_over_reg;

    // output shifter: first bit presented at select, next bits on rising clock
    always @(posedge core_clk)
    begin
        if (!rst_n)
            shift_out_reg <= `DIAG_RESET_VALUE;
        else if (cs_fall)
            shift_out_reg <= diag_word;
        else if (sclk_rise && pulse_cnt_reg != 5'h00)
            shift_out_reg <= {shift_out_reg[14:0], 1'b1};
    end

    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            so_o  <= 1'b0;
            so_oe <= 1'b0;
        end
        else
        begin
            so_o  <= shift_out_reg[15];
            so_oe <= !cs_n_s && !cs_n_d_reg;
        end
    end

    // output latch updates only when the frame closes
    always @(posedge core_clk)
    begin
        if (!rst_n)
            out_latch_reg <= `OUTPUT_RESET;
        else if (cs_rise && frame_ok &&
                 shift_in_reg[15:8] != `CTRL_DIAG_ONLY)
            out_latch_reg <= shift_in_reg[7:0];
    end

    // low-active parallel inputs are inverted when prg is low
    assign par_active = prg_s ? par_s : ~par_s;

    always @*
    begin
        power_next = out_latch_reg;
        power_next[3:0] = out_latch_reg[3:0] & par_active;
    end

    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            power_output <= `OUTPUT_RESET;
            fault_n_oe   <= 1'b0;
        end
        else
        begin
            power_output <= power_next;
            fault_n_oe   <= (diag_word != `DIAG_RESET_VALUE);
        end
    end

    assign fault_n_o = 1'b0;

endmodule // octal_switch_spi

`default_nettype wire

// >>> octal_switch_spi_assertions.sv
// concurrent checks on the ports of the octal switch serial block
`timescale 1ns/1ps
`default_nettype none
module octal_switch_spi_assertions (
    input wire logic       core_clk,      // core clock
    input wire logic       rst_n,         // sync reset, active low
    input wire logic       cs_n,          // chip select pin
    input wire logic [7:0] overload,      // current limit detectors
    input wire logic [7:0] open_load,     // open-load detectors
    input wire logic [7:0] short_gnd,     // short-to-ground detectors
    input wire logic       so_oe,         // serial out enable
    input wire logic       fault_n_oe,    // fault pull-down enable
    input wire logic [7:0] power_output,  // channel states
    input wire logic [7:0] out_latch_reg  // accepted data byte
);
    wire det = |{overload, open_load, short_gnd};
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // reset check runs during reset itself, so it opts out of the default disable
    property p_rst;
        disable iff (1'b0) !rst_n |=> !so_oe && power_output == 8'h00 && out_latch_reg == 8'h00;
    endproperty
    a_rst: assert property (p_rst)
        else $error("outputs not cleared by reset");
    property p_hiz; cs_n [*6] |-> !so_oe; endproperty
    a_hiz: assert property (p_hiz)
        else $error("serial out driven while deselected");
    property p_drive; (!cs_n) [*6] |-> so_oe; endproperty
    a_drive: assert property (p_drive)
        else $error("serial out not driven while selected");
    property p_fset; det |-> ##[1:8] fault_n_oe; endproperty
    a_fset: assert property (p_fset)
        else $error("fault flag not raised");
    property p_fclr;
        (!det) [*4] ##1 ($rose(cs_n) && !det) ##1 (!det) [*8] |-> !fault_n_oe;
    endproperty
    a_fclr: assert property (p_fclr)
        else $error("fault flag not released after clear");
    property p_hold_hi; cs_n [*8] |=> $stable(out_latch_reg) && $stable(power_output[7:4]);
    endproperty
    a_hold_hi: assert property (p_hold_hi)
        else $error("outputs changed while deselected");
    property p_hold_lo; (!cs_n) [*6] |=> $stable(out_latch_reg); endproperty
    a_hold_lo: assert property (p_hold_lo)
        else $error("latch changed during shifting");
    property p_upper; 1'b1 |=> power_output[7:4] == $past(out_latch_reg[7:4]); endproperty
    a_upper: assert property (p_upper)
        else $error("upper channels do not follow latch");
    property p_and_off; (out_latch_reg[3:0] == 4'h0) [*2] |=> power_output[3:0] == 4'h0;
    endproperty
    a_and_off: assert property (p_and_off)
        else $error("parallel channel on with serial bit off");
endmodule // octal_switch_spi_assertions
`default_nettype wire

// >>> spi_host_model.sv
// host microcontroller model acting as serial master
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    output var logic cs_n,  // chip select
    output var logic sclk,  // serial clock
    output var logic si,    // serial data to device
    input wire logic so_o,  // serial data from device
    input wire logic so_oe  // device drives serial out
);
    logic [15:0] rx_word;
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
    end
    // delays are multiples of the core period so edges stay just after core edges
    task automatic xfer(input logic [15:0] tx, input int pulses);
        rx_word = 16'h0000;
        cs_n = 1'b0;
        #252;
        for (int i = 15; i > 15 - pulses; i--)
        begin
            sclk = 1'b1;
            si = tx[i];
            #24;
            // an undriven line reads inverted so a missing enable shows up
            rx_word = {rx_word[14:0], so_oe ? so_o : ~so_o};
            sclk = 1'b0;
            #24;
        end
        si = ~si;
        #228;
        cs_n = 1'b1;
        #252;
    endtask
endmodule // spi_host_model
`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the octal switch serial block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic       core_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       prg = 1'b1;
    logic [3:0] par_in = 4'hf;
    logic [7:0] overload = 8'h00;
    logic [7:0] open_load = 8'h00;
    logic [7:0] short_gnd = 8'h00;
    wire        cs_n, sclk, si, so_o, so_oe, fault_n_o, fault_n_oe;
    wire  [7:0] power_output, out_latch_reg;
    wire        fault_line = fault_n_oe ? fault_n_o : 1'b1;  // board pull-up on the fault pin
    int         n_errors = 0;
    int         total_checks = 0;
    always #2 core_clk = ~core_clk;
    spi_host_model spi_host_model_i (.cs_n(cs_n), .sclk(sclk), .si(si), .so_o(so_o),
        .so_oe(so_oe));
    octal_switch_spi octal_switch_spi_i (.core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n),
        .sclk(sclk), .si(si), .so_o(so_o), .so_oe(so_oe), .fault_n_o(fault_n_o),
        .fault_n_oe(fault_n_oe), .prg(prg), .parallel_drive_input_1(par_in[0]),
        .parallel_drive_input_2(par_in[1]), .parallel_drive_input_3(par_in[2]),
        .parallel_drive_input_4(par_in[3]), .overload(overload), .open_load(open_load),
        .short_gnd(short_gnd), .power_output(power_output), .out_latch_reg(out_latch_reg));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic frame(input logic [15:0] tx, input int n);
        step(1);
        spi_host_model_i.xfer(tx, n);
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        step(5);
        check(power_output, 8'h00);
        check(so_oe, 1'b0);
        rst_n = 1'b1;
        step(4);
        frame(16'hffa5, 16);
        check(out_latch_reg, 8'ha5);
        check(power_output, 8'ha5);
        check(spi_host_model_i.rx_word, 16'hffff);
        $display("test control done");
        frame(16'h003c, 16);
        check(power_output, 8'ha5);
        frame(16'hff3c, 15);
        check(out_latch_reg, 8'ha5);
        par_in = 4'he;
        frame(16'h810f, 16);
        check(out_latch_reg, 8'h0f);
        check(power_output, 8'h0e);
        prg = 1'b0;
        par_in = 4'h1;
        step(6);
        check(power_output, 8'h0e);
        $display("test accept done");
        // ch2 sees overload then open load, so only the later code survives
        overload = 8'h82;
        short_gnd = 8'h08;
        step(8);
        check(fault_line, 1'b0);
        overload = 8'h00;
        short_gnd = 8'h00;
        open_load = 8'h03;
        step(8);
        open_load = 8'h00;
        step(8);
        check(fault_line, 1'b0);
        frame(16'h0000, 16);
        check(spi_host_model_i.rx_word, 16'hbf35);
        check(power_output, 8'h0e);
        check(fault_line, 1'b1);
        #150000;
        frame(16'h0000, 16);
        check(spi_host_model_i.rx_word, 16'hffff);
        $display("test diagnosis done");
        rst_n = 1'b0;
        step(5);
        check(power_output, 8'h00);
        check(out_latch_reg, 8'h00);
        check(so_oe, 1'b0);
        $display("test reset done");
        report_and_stop();
    end
    initial
    begin
        #300000;
        n_errors++;
        report_and_stop();
    end
endmodule // tb_top
bind octal_switch_spi octal_switch_spi_assertions chk_i (.core_clk(core_clk), .rst_n(rst_n),
    .cs_n(cs_n), .overload(overload), .open_load(open_load), .short_gnd(short_gnd),
    .so_oe(so_oe), .fault_n_oe(fault_n_oe), .power_output(power_output),
    .out_latch_reg(out_latch_reg));
`default_nettype wire
